// ### pkg/asi_pkg.sv
// Shared constants, carriers and state codes of the async serial interface
package asi_pkg;
    localparam int ADDR_W = 8; // APB byte address width
    localparam int DATA_W = 32; // APB data width
    localparam int DIV_W = 13; // Baud divisor width
    // Register byte offsets
    localparam logic [7:0] OFF_BDH = 8'h00;
    localparam logic [7:0] OFF_BDL = 8'h04;
    localparam logic [7:0] OFF_C1 = 8'h08;
    localparam logic [7:0] OFF_C2 = 8'h0c;
    localparam logic [7:0] OFF_S1 = 8'h10;
    localparam logic [7:0] OFF_S2 = 8'h14;
    localparam logic [7:0] OFF_C3 = 8'h18;
    localparam logic [7:0] OFF_DATA = 8'h1c;
    // Reset values; the low divisor byte comes up non-zero
    localparam logic [7:0] BDH_RST = 8'h00;
    localparam logic [7:0] BDL_RST = 8'h04;
    localparam logic [7:0] C1_RST = 8'h00;
    localparam logic [7:0] C2_RST = 8'h00;
    // Field positions
    localparam int BDH_BKIE = 7; // break_detect_irq_enable
    localparam int BDH_EDGIE = 6; // rx_edge_irq_enable
    localparam int C1_LOOP = 7; // loop_select
    localparam int C1_WFRZ = 6; // wait_freeze
    localparam int C1_RECEIVER_SOURCE = 5; // receiver_source
    localparam int C1_M = 4; // nine-bit frame
    localparam int C1_WAKE = 3; // address-mark wakeup
    localparam int C1_ILT = 2; // idle_count_start
    localparam int C1_PE = 1; // parity_enable
    localparam int C1_PT = 0; // parity_odd
    localparam int C2_TE = 3; // transmitter_enable
    localparam int C2_RE = 2; // receiver_enable
    localparam int C2_RWU = 1; // receiver standby
    localparam int C3_R8 = 7; // received ninth bit
    localparam int C3_T8 = 6; // ninth bit to send
    localparam int C3_DIR = 5; // single_wire_direction
    localparam int S2_BKF = 7; // break_detect_flag
    localparam int S2_EDGF = 6; // rx_edge_flag
    // Oversampling and frame timing, in 16x ticks and bits
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] FRAME_LEN_8 = 4'ha;
    localparam logic [3:0] FRAME_LEN_9 = 4'hb;
    localparam logic [3:0] IDLE_BITS_8 = 4'ha;
    localparam logic [3:0] IDLE_BITS_9 = 4'hb;
    // APB request carrier
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } asi_apb_req_t;
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } asi_rx_st_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SHIFT = 2'b10
    } asi_tx_st_t;
endpackage : asi_pkg

// ### rtl/asi_baud_gen.sv
// Modulo divider giving the 16x oversampling tick
`timescale 1ns/100ps
module asi_baud_gen #(
    parameter int DIV_W = asi_pkg::DIV_W // Divisor width
) (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, active low
    input wire logic [DIV_W-1:0] divisor, // Working divisor
    input wire logic run, // Generator allowed to count
    output logic tick // One-cycle 16x tick
);
    import asi_pkg::*;
    if (DIV_W < 1) begin : g_chk
        $error("divisor width must be at least one");
    end
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic tick;
    } asi_bg_st_t;
    asi_bg_st_t s_r, s_nxt;
    // Count to divisor-1 then tick, so ticks come at clk/divisor
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (!run || divisor == '0) begin // Stopped: hold at zero to save power
            s_nxt.cnt = '0;
        end else if (s_r.cnt >= divisor - 1'b1) begin
            s_nxt.cnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
    end
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign tick = s_r.tick;
endmodule : asi_baud_gen

// ### rtl/asi_tx_shift.sv
// Transmit shifter: start, 8 or 9 data bits LSB first, stop
`timescale 1ns/100ps
module asi_tx_shift (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, active low
    input wire logic tick, // 16x tick
    input wire logic go, // Load pulse
    input wire logic [8:0] frame, // Data with ninth bit on top
    input wire logic nine_bit, // Nine data bits
    output logic line, // Serial out, high at idle
    output logic busy // Frame in flight
);
    import asi_pkg::*;
    typedef struct packed {
        asi_tx_st_t st;
        logic [10:0] sh;
        logic [3:0] nbit;
        logic [3:0] tcnt;
        logic line;
        logic busy;
    } asi_tx_st_all_t;
    asi_tx_st_all_t s_r, s_nxt;
    // Shift one bit per 16 ticks; ones fill so the line rests high
    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            TX_IDLE: begin
                if (go) begin // Frame: stop, opt. ninth, data, start
                    s_nxt.sh = {1'b1, nine_bit ? frame[8] : 1'b1, frame[7:0], 1'b0};
                    s_nxt.nbit = nine_bit ? FRAME_LEN_9 : FRAME_LEN_8;
                    s_nxt.tcnt = '0;
                    s_nxt.busy = 1'b1;
                    s_nxt.st = TX_SHIFT;
                end
            end
            TX_SHIFT: begin
                if (tick) begin
                    s_nxt.tcnt = s_r.tcnt + 1'b1;
                    if (s_r.tcnt == TICK_LAST) begin
                        s_nxt.sh = {1'b1, s_r.sh[10:1]};
                        s_nxt.nbit = s_r.nbit - 1'b1;
                        if (s_r.nbit == 4'h1) begin
                            s_nxt.busy = 1'b0;
                            s_nxt.st = TX_IDLE;
                        end
                    end
                end
            end
            default: begin
                s_nxt.st = TX_IDLE;
            end
        endcase
        s_nxt.line = s_nxt.sh[0];
    end
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{st: TX_IDLE, sh: '1, nbit: '0, tcnt: '0, line: 1'b1, busy: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end
    assign line = s_r.line;
    assign busy = s_r.busy;
endmodule : asi_tx_shift

// ### rtl/asi_core.sv
// Async serial interface: registers, baud control, frame options, receiver
// Function
// R1: Eight byte-wide software registers
// R2: Divisor high 5 bits, low 8 bits
// R3: High byte buffered until low byte written
// R4: Zero divisor stops the baud generator
// R5: Bit rate is clock over 16 times divisor
// R6: Baud idle until first receiver/transmitter enable
// R7: Break flag interrupts when its enable set
// R8: Receive edge flag interrupts when enabled
// R9: Loop mode feeds transmitter into receiver
// R10: Receiver source: loop-back or single wire
// R11: Wait freeze stops clocks during wait
// R12: Frame eight or nine data bits
// R13: Wakeup by idle line or address mark
// R14: Idle count starts after start or stop
// R15: Parity generated and checked on data MSB
// R16: Parity even or odd over all ones
// R17: Single wire direction controls shared pin
// R18: Unused divisor high bit reads zero
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/100ps
module asi_core #(
    parameter int DIV_W = asi_pkg::DIV_W // Divisor width
) (
    input wire logic pclk, // Bus clock, 200 MHz
    input wire logic presetn, // Async reset, active low
    input wire asi_pkg::asi_apb_req_t apb_req, // APB request signals
    output logic [asi_pkg::DATA_W-1:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic rxd_pin, // Receive pin level
    input wire logic txd_pin_i, // Transmit pin level seen back
    output logic txd_pin_o, // Transmit pin drive value
    output logic txd_pin_oe, // Transmit pin drive enable
    input wire logic cpu_wait, // Processor in wait mode
    output logic irq // Interrupt request, active high
);
    import asi_pkg::*;
    if (DIV_W != 13) begin : g_chk
        $error("divisor layout needs exactly 13 bits");
    end
    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [7:0] bdh; // Enables plus buffered high divisor
        logic [DIV_W-1:0] div; // Working divisor
        logic [7:0] c1; // Frame and routing options
        logic [7:0] c2; // Enables and standby
        logic single_wire_direction; // Single-wire drive direction
        logic baud_on; // Set by first enable write
        logic [8:0] tx_buf; // Pending transmit character
        logic tx_empty; // Transmit buffer free
        logic tx_go; // Load pulse to shifter
        logic [8:0] tx_frame; // Character handed to shifter
        asi_rx_st_t rx_st; // Receiver state
        logic [3:0] rx_tcnt; // Tick counter in a bit
        logic [3:0] rx_bitn; // Data bits taken
        logic [8:0] rx_sh; // Receive shift register
        logic [8:0] rx_data; // Received character
        logic rx_full; // Receive data ready
        logic ovr; // Overrun
        logic fe; // Framing error
        logic pf; // Parity error
        logic idle_f; // Idle line seen
        logic [3:0] idle_cnt; // High bit times counted
        logic [3:0] idle_tcnt; // Ticks in an idle bit
        logic idle_arm; // Character seen since last idle
        logic bkf; // Break detect flag
        logic edgf; // Receive edge flag
        logic rx_prev; // Receive input last cycle
        logic [DATA_W-1:0] prdata; // Bus read data
        logic pready; // Bus ready
        logic pslverr; // Bus error
        logic txd_o; // Pin value
        logic txd_oe; // Pin enable
        logic irq; // Interrupt request
    } asi_core_st_t;
    asi_core_st_t s_r, s_nxt;
    logic tick; // 16x tick
    logic tx_line; // Shifter output
    logic tx_busy; // Shifter busy
    logic baud_run; // Generator enable
    logic rx_in; // Selected receive source
    logic single_wire; // Loop plus external pin
    logic [7:0] rd_byte; // Read mux
    logic addr_ok; // Mapped address
    logic [7:0] offs; // Request offset
    logic done; // Access completes this edge
    logic wr; // Write completes
    logic nine; // Nine-bit frames
    logic [3:0] need; // Idle bits needed
    logic [8:0] rx_word; // Aligned received character
    logic par_bit; // Received data parity
    ////////////////////////////////////////////////////////////////////////
    // Baud generator and transmitter
    // Frozen in wait only when chosen, so the block can wake the CPU
    assign baud_run = s_r.baud_on && !(s_r.c1[C1_WFRZ] && cpu_wait); // R6 R11
    asi_baud_gen #(.DIV_W(DIV_W)) u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .divisor(s_r.div), // R4 R5
        .run(baud_run),
        .tick(tick)
    );
    asi_tx_shift u_tx (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .go(s_r.tx_go),
        .frame(s_r.tx_frame),
        .nine_bit(s_r.c1[C1_M]), // R12
        .line(tx_line),
        .busy(tx_busy)
    );
    ////////////////////////////////////////////////////////////////////////
    // Routing and decode
    // The receive pin is unused whenever loop mode is on
    assign single_wire = s_r.c1[C1_LOOP] && s_r.c1[C1_RECEIVER_SOURCE]; // R10
    always_comb begin
        if (!s_r.c1[C1_LOOP]) begin
            rx_in = rxd_pin;
        end else if (s_r.c1[C1_RECEIVER_SOURCE]) begin
            rx_in = txd_pin_i; // R10
        end else begin
            rx_in = tx_line; // R9
        end
    end
    assign offs = apb_req.paddr[7:0];
    assign done = apb_req.psel && apb_req.penable && s_r.pready;
    assign wr = done && apb_req.pwrite && addr_ok;
    assign nine = s_r.c1[C1_M];
    assign need = nine ? IDLE_BITS_9 : IDLE_BITS_8; // R14
    assign rx_word = nine ? s_r.rx_sh : {1'b0, s_r.rx_sh[8:1]};
    assign par_bit = nine ? ^s_r.rx_sh : ^s_r.rx_sh[8:1];
    // Read mux; reserved bits read zero
    always_comb begin
        addr_ok = 1'b1;
        rd_byte = 8'h00;
        case (offs) // R1
            OFF_BDH: rd_byte = {s_r.bdh[7:6], 1'b0, s_r.bdh[4:0]}; // R18
            OFF_BDL: rd_byte = s_r.div[7:0];
            OFF_C1: rd_byte = s_r.c1;
            OFF_C2: rd_byte = s_r.c2;
            OFF_S1: rd_byte = {s_r.tx_empty, s_r.tx_empty && !tx_busy && !s_r.tx_go,
                s_r.rx_full, s_r.idle_f, s_r.ovr, 1'b0, s_r.fe, s_r.pf};
            OFF_S2: rd_byte = {s_r.bkf, s_r.edgf, 6'h00};
            OFF_C3: rd_byte = {s_r.rx_data[8], s_r.tx_buf[8], s_r.single_wire_direction, 5'h00};
            OFF_DATA: rd_byte = s_r.rx_data[7:0];
            default: addr_ok = 1'b0;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.tx_go = 1'b0;
        // APB: one wait cycle, then ready; effects at the ready edge
        if (done) begin
            s_nxt.pready = 1'b0;
            s_nxt.pslverr = 1'b0;
        end else if (apb_req.psel && apb_req.penable) begin
            s_nxt.pready = 1'b1;
            s_nxt.pslverr = !addr_ok;
            s_nxt.prdata = {24'h000000, rd_byte};
        end
        // Reading data releases the receive flags
        if (done && !apb_req.pwrite && offs == OFF_DATA) begin
            s_nxt.rx_full = 1'b0;
            s_nxt.ovr = 1'b0;
            s_nxt.fe = 1'b0;
            s_nxt.pf = 1'b0;
            s_nxt.idle_f = 1'b0;
        end
        // Register writes
        if (wr) begin
            case (offs)
                OFF_BDH: begin // Bit 5 has no storage
                    s_nxt.bdh = {apb_req.pwdata[7:6], 1'b0, apb_req.pwdata[4:0]}; // R2 R18
                end
                OFF_BDL: begin // High byte takes effect only now
                    s_nxt.div = {s_r.bdh[4:0], apb_req.pwdata[7:0]}; // R2 R3
                end
                OFF_C1: s_nxt.c1 = apb_req.pwdata[7:0];
                OFF_C2: begin
                    s_nxt.c2 = {4'h0, apb_req.pwdata[3:1], 1'b0};
                    if (apb_req.pwdata[C2_TE] || apb_req.pwdata[C2_RE]) begin
                        s_nxt.baud_on = 1'b1; // R6
                    end
                end
                OFF_S2: begin // Write one to clear
                    if (apb_req.pwdata[S2_BKF]) begin
                        s_nxt.bkf = 1'b0;
                    end
                    if (apb_req.pwdata[S2_EDGF]) begin
                        s_nxt.edgf = 1'b0;
                    end
                end
                OFF_C3: begin
                    s_nxt.tx_buf[8] = apb_req.pwdata[C3_T8];
                    s_nxt.single_wire_direction = apb_req.pwdata[C3_DIR];
                end
                OFF_DATA: begin
                    s_nxt.tx_buf[7:0] = apb_req.pwdata[7:0];
                    s_nxt.tx_empty = 1'b0;
                end
                default: begin
                end
            endcase
        end
        // Transmit hand-off, parity put in the MSB when enabled
        if (s_r.c2[C2_TE] && !s_r.tx_empty && !tx_busy && !s_r.tx_go) begin
            s_nxt.tx_go = 1'b1;
            // A data write in the hand-off cycle stays pending, not lost
            s_nxt.tx_empty = !(wr && offs == OFF_DATA);
            s_nxt.tx_frame = s_r.tx_buf;
            if (s_r.c1[C1_PE] && nine) begin
                s_nxt.tx_frame[8] = ^s_r.tx_buf[7:0] ^ s_r.c1[C1_PT]; // R15 R16
            end else if (s_r.c1[C1_PE]) begin
                s_nxt.tx_frame[7] = ^s_r.tx_buf[6:0] ^ s_r.c1[C1_PT]; // R15 R16
            end
        end
        // Receive edge flag; set wins over a same-cycle clear
        s_nxt.rx_prev = rx_in;
        if (s_r.c2[C2_RE] && s_r.rx_prev && !rx_in) begin
            s_nxt.edgf = 1'b1;
        end
        // Receiver, stepped by the 16x tick
        case (s_r.rx_st)
            RX_IDLE: begin
                if (s_r.c2[C2_RE] && !rx_in && tick) begin
                    s_nxt.rx_st = RX_START;
                    s_nxt.rx_tcnt = '0;
                    s_nxt.idle_cnt = '0;
                    s_nxt.idle_tcnt = '0;
                end else if (tick && rx_in) begin // Idle line bit timer
                    s_nxt.idle_tcnt = s_r.idle_tcnt + 1'b1;
                    if (s_r.idle_tcnt == TICK_LAST && s_r.idle_cnt < need) begin
                        s_nxt.idle_cnt = s_r.idle_cnt + 1'b1;
                    end
                end
            end
            RX_START: begin // Confirm start in mid bit, else a glitch
                if (tick) begin
                    s_nxt.rx_tcnt = s_r.rx_tcnt + 1'b1;
                    if (s_r.rx_tcnt == TICK_MID) begin
                        s_nxt.rx_tcnt = '0;
                        s_nxt.rx_bitn = '0;
                        s_nxt.rx_st = rx_in ? RX_IDLE : RX_DATA;
                    end
                end
            end
            RX_DATA: begin // Sample each data bit in its middle
                if (tick) begin
                    s_nxt.rx_tcnt = s_r.rx_tcnt + 1'b1;
                    if (s_r.rx_tcnt == TICK_LAST) begin
                        s_nxt.rx_sh = {rx_in, s_r.rx_sh[8:1]}; // R12
                        s_nxt.rx_bitn = s_r.rx_bitn + 1'b1;
                        // High data bits count as idle unless counting waits for stop
                        if (!rx_in) begin
                            s_nxt.idle_cnt = '0;
                        end else if (!s_r.c1[C1_ILT] && s_r.idle_cnt < need) begin
                            s_nxt.idle_cnt = s_r.idle_cnt + 1'b1; // R14
                        end
                        if (s_r.rx_bitn == (nine ? 4'h8 : 4'h7)) begin
                            s_nxt.rx_st = RX_STOP;
                        end
                    end
                end
            end
            RX_STOP: begin
                if (tick) begin
                    s_nxt.rx_tcnt = s_r.rx_tcnt + 1'b1;
                    if (s_r.rx_tcnt == TICK_LAST) begin
                        s_nxt.rx_st = RX_IDLE;
                        s_nxt.idle_tcnt = '0;
                        s_nxt.idle_arm = 1'b1;
                        if (s_r.c1[C1_ILT] || !rx_in) begin
                            s_nxt.idle_cnt = '0; // R14
                        end else if (s_r.idle_cnt < need) begin
                            s_nxt.idle_cnt = s_r.idle_cnt + 1'b1;
                        end
                        if (!rx_in && rx_word == '0) begin
                            s_nxt.bkf = 1'b1; // Break: all zero, no stop bit
                        end
                        if (s_r.c2[C2_RWU]) begin
                            // Standby: only an address mark wakes and is kept
                            if (s_r.c1[C1_WAKE] && rx_word[nine ? 8 : 7]) begin
                                s_nxt.c2[C2_RWU] = 1'b0; // R13
                                s_nxt.rx_data = rx_word;
                                s_nxt.rx_full = 1'b1;
                            end
                        end else if (s_r.rx_full) begin
                            s_nxt.ovr = 1'b1;
                        end else begin
                            s_nxt.rx_data = rx_word;
                            s_nxt.rx_full = 1'b1;
                            s_nxt.fe = !rx_in;
                            s_nxt.pf = s_r.c1[C1_PE] && (par_bit != s_r.c1[C1_PT]); // R15 R16
                        end
                    end
                end
            end
            default: begin
                s_nxt.rx_st = RX_IDLE;
            end
        endcase
        // Idle line flag and idle-line wakeup
        if (s_r.idle_arm && s_r.idle_cnt >= need) begin
            s_nxt.idle_arm = 1'b0;
            if (s_r.c2[C2_RWU] && !s_r.c1[C1_WAKE]) begin
                s_nxt.c2[C2_RWU] = 1'b0; // R13
            end else begin
                s_nxt.idle_f = 1'b1;
            end
        end
        // Pin: shifter keeps it until its frame ends even after disable
        s_nxt.txd_o = tx_line;
        s_nxt.txd_oe = (s_r.c2[C2_TE] || tx_busy) && (!single_wire || s_r.single_wire_direction); // R17
        // Interrupt from enabled sticky flags
        s_nxt.irq = (s_r.bdh[BDH_BKIE] && s_r.bkf) // R7
            || (s_r.bdh[BDH_EDGIE] && s_r.edgf); // R8
    end
    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.bdh <= BDH_RST;
            s_r.div <= {BDH_RST[4:0], BDL_RST};
            s_r.c1 <= C1_RST;
            s_r.c2 <= C2_RST;
            s_r.tx_empty <= 1'b1;
            s_r.rx_st <= RX_IDLE;
            s_r.rx_prev <= 1'b1;
            s_r.txd_o <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from the state register
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign txd_pin_o = s_r.txd_o;
    assign txd_pin_oe = s_r.txd_oe;
    assign irq = s_r.irq;
endmodule : asi_core

// ### dv/asi_core_assertions.sv
// Port checker of the async serial core
`timescale 1ns/100ps
module asi_core_assertions (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire asi_pkg::asi_apb_req_t apb_req, // Request
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic txd_pin_o, // Serial out
    input wire logic irq // Interrupt
);
    import asi_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd = pready && !apb_req.pwrite; // Read ends
    chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
    chk_one_wait: assert property (apb_req.psel && apb_req.penable && !pready |=> pready)
        else $error("no ready");
    chk_byte_wide: assert property (rd |-> prdata[31:8] == 24'h0) else $error("high bits");
    chk_err_read: assert property (pslverr |-> pready && (apb_req.pwrite || prdata == 32'h0))
        else $error("bad error");
    chk_bdh_gap: assert property (rd && apb_req.paddr == OFF_BDH |-> !prdata[5]) else $error("bit5");
    chk_irq_masked: assert property (pready && apb_req.pwrite && apb_req.paddr == OFF_BDH
        && apb_req.pwdata[7:6] == 2'b00 |-> ##2 !irq) else $error("irq unmasked");
    chk_low_bit: assert property ($fell(txd_pin_o) |-> !txd_pin_o [*8] ##1 !txd_pin_o [*8])
        else $error("short low");
    chk_high_bit: assert property ($rose(txd_pin_o) |-> txd_pin_o [*8] ##1 txd_pin_o [*8])
        else $error("short high");
    cover property (pslverr);
    cover property (irq);
    cover property ($fell(txd_pin_o));
endmodule : asi_core_assertions
bind asi_core asi_core_assertions i_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd_pin_o(txd_pin_o), .irq(irq));

// ### dv/asi_remote_node.sv
// Remote serial node: sends and captures 8-bit frames
`timescale 1ns/100ps
module asi_remote_node #(
    parameter int BIT_CYC = 16 // Clocks per bit
) (
    input wire logic pclk, // Clock
    input wire logic line_in, // From device
    output logic line_out = 1'b1, // To device, idle high
    input wire logic [7:0] send_byte, // Byte to send
    input wire logic send_go, // Rise starts a frame
    output logic [8:0] got_word = '0, // Stop bit over data
    output int got_count = 0 // Frames taken
);
    // Sender: start, LSB first, stop
    always @(posedge send_go) begin
        line_out <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            repeat (BIT_CYC) @(posedge pclk);
            line_out <= (i >= 8) ? 1'b1 : send_byte[i];
        end
    end
    // Receiver: sample mid bit, so drift of a few clocks is tolerated
    always begin
        @(negedge line_in);
        repeat (BIT_CYC / 2) @(posedge pclk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT_CYC) @(posedge pclk);
            got_word[i] <= line_in;
        end
        got_count <= got_count + 1;
    end
endmodule : asi_remote_node

// ### dv/uart_baud_and_frame_control_bench.sv
// Self-checking bench of the async serial core
`timescale 1ns/100ps
module uart_baud_and_frame_control_bench;
    import asi_pkg::*;
    logic pclk = 1'b0; // Clock
    logic presetn = 1'b0; // Reset
    asi_apb_req_t req = '0; // Request
    logic [31:0] prdata; // Read data
    logic pready, pslverr, err, irq, txd_o, txd_oe, rxd, nb_go = 1'b0, wt = 1'b0; // Handshake, lines, wait
    logic [7:0] nb_byte = 8'h00, rd, lfsr = 8'h17, cfg; // Node byte, read, random, options
    logic [8:0] nb_word; // Captured frame
    int nb_count, failures = 0, check_count = 0, n0; // Counters
    logic [7:0] exp_q[$]; // Model of bytes due on the wire
    asi_core i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd_pin(rxd), .txd_pin_i(txd_oe ? txd_o : 1'b1), .txd_pin_o(txd_o),
        .txd_pin_oe(txd_oe), .cpu_wait(wt), .irq(irq));
    asi_remote_node i_node (.pclk(pclk), .line_in(txd_o), .line_out(rxd), .send_byte(nb_byte),
        .send_go(nb_go), .got_word(nb_word), .got_count(nb_count));
    initial forever #2.5 pclk = ~pclk;
    task automatic test_done();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer; data taken at the ready edge only
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, wr, a, {24'h0, d}};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) begin
            failures++;
            test_done();
        end
        rd = prdata[7:0];
        err = pslverr;
        req <= '0;
    endtask : apb
    function automatic logic [7:0] next_rand(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : next_rand
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_BDH, 8'h00);
        check(rd, BDH_RST);
        apb(1'b0, OFF_BDL, 8'h00);
        check(rd, BDL_RST);
        apb(1'b0, 8'h20, 8'h00);
        check({err, rd}, 9'h100);
        lfsr = next_rand(lfsr);
        apb(1'b1, OFF_BDH, lfsr | 8'h20);
        apb(1'b0, OFF_BDH, 8'h00);
        check(rd, lfsr & 8'hdf);
        apb(1'b1, OFF_BDH, 8'h00);
        apb(1'b1, OFF_BDL, 8'h01);
        apb(1'b1, OFF_C2, 8'h0c);
        apb(1'b1, OFF_BDH, 8'h1f);
        $display("registers done");
        // Plain, even and odd parity frames
        for (int p = 0; p < 3; p++) begin
            lfsr = next_rand(lfsr);
            cfg = (p == 0) ? 8'h00 : 8'(p + 1);
            exp_q.push_back(cfg[1] ? {^lfsr[6:0] ^ cfg[0], lfsr[6:0]} : lfsr);
            apb(1'b1, OFF_C1, cfg);
            n0 = nb_count;
            apb(1'b1, OFF_DATA, lfsr);
            for (int n = 0; n < 1000 && nb_count == n0; n++) @(posedge pclk);
            if (nb_count == n0) begin
                failures++;
                test_done();
            end
            check(nb_word, {1'b1, exp_q.pop_front()});
        end
        check(txd_oe, 1'b1);
        $display("transmit done");
        // Received frame raises the edge flag
        apb(1'b1, OFF_C1, 8'h00);
        apb(1'b1, OFF_BDH, 8'h40);
        nb_byte <= next_rand(lfsr);
        nb_go <= 1'b1;
        repeat (170) @(posedge pclk);
        check(irq, 1'b1);
        apb(1'b0, OFF_DATA, 8'h00);
        check(rd, nb_byte);
        apb(1'b1, OFF_BDH, 8'h00);
        repeat (2) @(posedge pclk);
        check(irq, 1'b0);
        $display("receive done");
        // Wait freeze must hold the start bit of an all-ones byte
        apb(1'b1, OFF_C1, 8'h40);
        wt <= 1'b1;
        apb(1'b1, OFF_DATA, 8'hff);
        repeat (100) @(posedge pclk);
        check(txd_o, 1'b0);
        $display("freeze done");
        test_done();
    end
endmodule : uart_baud_and_frame_control_bench
